// *** logic/lfw_regs.svh ***
`ifndef LFW_REGS_SVH
`define LFW_REGS_SVH

// ----------------------------------------------------------------------
// Clock and timing figures
// ----------------------------------------------------------------------
`define LFW_CLK_MHZ 40
`define LFW_T_SG_MIN_NS 124000
`define LFW_T_SG_MAX_NS 2030000
`define LFW_T_SGB_MIN_NS 256000
`define LFW_T_SB_MIN_NS 593000
`define LFW_T_SBG_MAX_NS 1015000
`define LFW_T_HALFBIT_NS 128000
// Least times round up and longest times round down to whole cycles.
`define LFW_CYC_UP(ns) ((((ns) * `LFW_CLK_MHZ) + 999) / 1000)
`define LFW_CYC_DN(ns) (((ns) * `LFW_CLK_MHZ) / 1000)
`define LFW_CNT_W 18

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define LFW_OFS_CTRL 3'h0
`define LFW_OFS_IMASK 3'h1
`define LFW_OFS_FLAGS 3'h2
`define LFW_OFS_HDRCMP 3'h3
`define LFW_OFS_IDH 3'h4
`define LFW_OFS_IDL 3'h5
`define LFW_OFS_RXDATA 3'h6
`define LFW_OFS_STATUS 3'h7

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define LFW_CTRL_EN 0
`define LFW_CTRL_PAT_LO 1
`define LFW_CTRL_BURST 3
`define LFW_CTRL_SBRST 4
`define LFW_FLG_WAKE 0
`define LFW_FLG_FRAME 1
`define LFW_FLG_EOD 2
`define LFW_PAT_MODE1 2'h0
`define LFW_PAT_HDR 2'h1
`define LFW_PAT_HDRID 2'h2
`define LFW_PAT_TRANSP 2'h3
`define LFW_HDR_BITS 7
`define LFW_ID_BITS 16
`define LFW_FRAME_BITS 8
`define LFW_RST_BYTE 8'h00

`endif

// *** logic/lfw_pkg.sv ***
package lfw_pkg;

	// Sequencer states.
	typedef enum logic [3:0] {
		ST_STANDBY,
		ST_PRE,
		ST_PGAP,
		ST_SB,
		ST_GAP,
		ST_SYNC,
		ST_HDR,
		ST_IDENT,
		ST_DATA,
		ST_TRANSP
	} lfw_state_t;

	// Software control bits.
	typedef struct packed {
		logic burst;
		logic [1:0] pattern;
		logic en;
	} lfw_ctrl_t;

	// Sticky event flags and their masks share one layout.
	typedef struct packed {
		logic eod;
		logic frame;
		logic wake;
	} lfw_flags_t;

endpackage

// *** logic/lfw_manchester.sv ***
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Manchester bit recovery, rising mid-bit edge means one
// ----------------------------------------------------------------------
module lfw_manchester #(
	parameter int HALF = 5120
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic start,
	input wire logic run,
	input wire logic env,
	output logic bitStb,
	output logic bitVal,
	output logic stall
);
	import lfw_pkg::*;

	localparam logic [17:0] EDGE_MIN = 18'((3 * HALF) / 2);
	localparam logic [17:0] LOST = 18'(3 * HALF);

	logic [17:0] t_r, t_nxt;
	logic prev_r, prev_nxt;
	logic live_r, live_nxt;
	logic stb_r, stb_nxt;
	logic val_r, val_nxt;
	logic stall_r, stall_nxt;

	// Edges closer than three quarters of a bit to the last mid-bit edge
	// are boundary edges and carry no data.
	always_comb begin
		t_nxt = t_r;
		prev_nxt = env;
		live_nxt = live_r;
		stb_nxt = 1'b0;
		val_nxt = val_r;
		stall_nxt = 1'b0;
		if (start) begin
			t_nxt = 18'h00000;
			live_nxt = 1'b1;
		end else if (!run) begin
			live_nxt = 1'b0;
		end else if (live_r) begin
			if (env != prev_r && t_r >= EDGE_MIN) begin
				stb_nxt = 1'b1;
				val_nxt = env;
				t_nxt = 18'h00000;
			end else if (t_r > LOST) begin
				// Stalling once keeps the end report a single pulse.
				stall_nxt = 1'b1;
				live_nxt = 1'b0;
			end else begin
				t_nxt = t_r + 18'h00001;
			end
		end
	end

	// State registers.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			t_r <= 18'h00000;
			prev_r <= 1'b0;
			live_r <= 1'b0;
			stb_r <= 1'b0;
			val_r <= 1'b0;
			stall_r <= 1'b0;
		end else begin
			t_r <= t_nxt;
			prev_r <= prev_nxt;
			live_r <= live_nxt;
			stb_r <= stb_nxt;
			val_r <= val_nxt;
			stall_r <= stall_nxt;
		end
	end

	assign bitStb = stb_r;
	assign bitVal = val_r;
	assign stall = stall_r;

endmodule

// *** logic/lfw_wakeup_decoder.sv ***
// Behaviour
// - Pattern 01, continuous: preamble, valid start gap, sync on burst fall.
// - Header modes: seven Manchester header bits; pattern 01 sets wake flag at last bit.
// - Pattern 10, continuous: header then sixteen-bit identifier before wake.
// - After wake, data arrives as byte frames, each raising frame flag.
// - Invalid start, header, identifier or gap over 2.03 ms returns standby.
// - Clearing receiver enable forces standby like a timeout.
// - Burst mode, pattern 01: start burst, gap, sync burst, header.
// - Burst mode, pattern 10: header plus identifier before wake.
// - Pattern 11 bypasses decoding, presents demodulated data for capture.
// - Transparent entry starts slow oscillator and gives first capture.
// - Received header is checked against the header compare value.
// - End-of-data flag on bit error, correct end or timeout.
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "lfw_regs.svh"

module lfw_wakeup_decoder #(
	parameter int SG_MIN = `LFW_CYC_UP(`LFW_T_SG_MIN_NS),
	parameter int SG_MAX = `LFW_CYC_DN(`LFW_T_SG_MAX_NS),
	parameter int SGB_MIN = `LFW_CYC_UP(`LFW_T_SGB_MIN_NS),
	parameter int SB_MIN = `LFW_CYC_UP(`LFW_T_SB_MIN_NS),
	parameter int SBG_MAX = `LFW_CYC_DN(`LFW_T_SBG_MAX_NS),
	parameter int HALF_BIT = `LFW_CYC_UP(`LFW_T_HALFBIT_NS)
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [2:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	output logic [7:0] rdData,
	input wire logic envPin,
	input wire logic preamblePin,
	output logic wakeIrq,
	output logic frameIrq,
	output logic eodIrq,
	output logic demodDataOut,
	output logic captureEvent,
	output logic oscRun
);
	import lfw_pkg::*;

	localparam logic [17:0] C_SG_MIN = 18'(SG_MIN);
	localparam logic [17:0] C_SG_MAX = 18'(SG_MAX);
	localparam logic [17:0] C_SGB_MIN = 18'(SGB_MIN);
	localparam logic [17:0] C_SB_MIN = 18'(SB_MIN);
	localparam logic [17:0] C_SBG_MAX = 18'(SBG_MAX);

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic envS1_r, envS2_r, preS1_r, preS2_r, envPrev_r;

	// Both pins come from the analogue front end, outside this clock.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			envS1_r <= 1'b0;
			envS2_r <= 1'b0;
			preS1_r <= 1'b0;
			preS2_r <= 1'b0;
			envPrev_r <= 1'b0;
		end else begin
			envS1_r <= envPin;
			envS2_r <= envS1_r;
			preS1_r <= preamblePin;
			preS2_r <= preS1_r;
			envPrev_r <= envS2_r;
		end
	end

	logic env, envRise, envFall;
	assign env = envS2_r;
	assign envRise = env & ~envPrev_r;
	assign envFall = ~env & envPrev_r;

	// ------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------
	lfw_ctrl_t ctrl_r, ctrl_nxt;
	lfw_flags_t mask_r, mask_nxt, flags_r, flags_nxt, flagSet;
	logic [6:0] hdrCmp_r, hdrCmp_nxt;
	logic [15:0] idCmp_r, idCmp_nxt;
	logic [7:0] rxData_r, rxData_nxt, rdData_r, rdData_nxt;
	logic [7:0] rxLoad;
	logic rxLoadStb, sbReset;
	lfw_state_t state_r, state_nxt;

	function automatic logic wrHit(input logic [2:0] a, input logic [2:0] o,
		input logic s);
		wrHit = s && (a == o);
	endfunction

	// Writes store fields; the flag register clears by writing ones, and a
	// hardware set in the same cycle wins over the clear.
	always_comb begin
		ctrl_nxt = ctrl_r;
		mask_nxt = mask_r;
		hdrCmp_nxt = hdrCmp_r;
		idCmp_nxt = idCmp_r;
		sbReset = 1'b0;
		flags_nxt = flags_r;
		rxData_nxt = rxLoadStb ? rxLoad : rxData_r;
		if (wrHit(addr, `LFW_OFS_CTRL, wrStb)) begin
			ctrl_nxt = lfw_ctrl_t'(wrData[3:0]);
			sbReset = wrData[`LFW_CTRL_SBRST];
		end
		if (wrHit(addr, `LFW_OFS_IMASK, wrStb))
			mask_nxt = lfw_flags_t'(wrData[2:0]);
		if (wrHit(addr, `LFW_OFS_HDRCMP, wrStb))
			hdrCmp_nxt = wrData[6:0];
		if (wrHit(addr, `LFW_OFS_IDH, wrStb))
			idCmp_nxt[15:8] = wrData;
		if (wrHit(addr, `LFW_OFS_IDL, wrStb))
			idCmp_nxt[7:0] = wrData;
		if (wrHit(addr, `LFW_OFS_FLAGS, wrStb))
			flags_nxt = flags_r & ~lfw_flags_t'(wrData[2:0]);
		flags_nxt = flags_nxt | flagSet;
	end

	// Read data stand for exactly the cycle after the read strobe.
	always_comb begin
		rdData_nxt = `LFW_RST_BYTE;
		if (rdStb) begin
			unique case (addr)
				`LFW_OFS_CTRL: rdData_nxt = {4'h0, ctrl_r};
				`LFW_OFS_IMASK: rdData_nxt = {5'h00, mask_r};
				`LFW_OFS_FLAGS: rdData_nxt = {5'h00, flags_r};
				`LFW_OFS_HDRCMP: rdData_nxt = {1'b0, hdrCmp_r};
				`LFW_OFS_IDH: rdData_nxt = idCmp_r[15:8];
				`LFW_OFS_IDL: rdData_nxt = idCmp_r[7:0];
				`LFW_OFS_RXDATA: rdData_nxt = rxData_r;
				`LFW_OFS_STATUS: rdData_nxt = {4'h0, state_r};
			endcase
		end
	end

	// Register file state.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_r <= lfw_ctrl_t'(4'h0);
			mask_r <= lfw_flags_t'(3'h0);
			flags_r <= lfw_flags_t'(3'h0);
			hdrCmp_r <= 7'h00;
			idCmp_r <= 16'h0000;
			rxData_r <= `LFW_RST_BYTE;
			rdData_r <= `LFW_RST_BYTE;
		end else begin
			ctrl_r <= ctrl_nxt;
			mask_r <= mask_nxt;
			flags_r <= flags_nxt;
			hdrCmp_r <= hdrCmp_nxt;
			idCmp_r <= idCmp_nxt;
			rxData_r <= rxData_nxt;
			rdData_r <= rdData_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Bit recovery
	// ------------------------------------------------------------------
	logic decStart, decRun, bitStb, bitVal, stall;

	lfw_manchester #(
		.HALF(HALF_BIT)
	) u_bits (
		.clk(clk),
		.nrst(nrst),
		.start(decStart),
		.run(decRun),
		.env(env),
		.bitStb(bitStb),
		.bitVal(bitVal),
		.stall(stall)
	);

	// ------------------------------------------------------------------
	// Wake-up sequencer
	// ------------------------------------------------------------------
	logic [17:0] cnt_r, cnt_nxt, gap_r, gap_nxt;
	logic [15:0] sh_r, sh_nxt;
	logic [4:0] bits_r, bits_nxt;
	logic longGap_r, longGap_nxt;
	logic capPulse, gapTo;
	logic [17:0] gapMax;

	assign gapMax = longGap_r ? C_SG_MAX : C_SBG_MAX;
	assign decRun = (state_r == ST_HDR) || (state_r == ST_IDENT) ||
		(state_r == ST_DATA);
	assign gapTo = decRun && (gap_r > C_SG_MAX);

	// Every phase after the preamble up to the sync fall is timed by one counter that restarts at each phase change.
	// A single counter keeps area small but means a phase only sees the
	// edge that ends it, so glitches inside a burst end that burst early.
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = (cnt_r == 18'h3ffff) ? cnt_r : cnt_r + 18'h00001;
		gap_nxt = (env != envPrev_r) ? 18'h00000 : gap_r + 18'h00001;
		sh_nxt = sh_r;
		bits_nxt = bits_r;
		longGap_nxt = longGap_r;
		decStart = 1'b0;
		flagSet = lfw_flags_t'(3'h0);
		rxLoad = {sh_r[6:0], bitVal};
		rxLoadStb = 1'b0;
		capPulse = 1'b0;
		if (!decRun)
			gap_nxt = 18'h00000;
		unique case (state_r)
			ST_STANDBY: begin
				cnt_nxt = 18'h00000;
				if (ctrl_r.en && preS2_r) begin
					if (ctrl_r.pattern == `LFW_PAT_TRANSP) begin
						state_nxt = ST_TRANSP;
						capPulse = 1'b1;
					end else begin
						state_nxt = ST_PRE;
					end
				end
			end
			ST_PRE: begin
				cnt_nxt = 18'h00000;
				if (!env) begin
					longGap_nxt = !ctrl_r.burst;
					state_nxt = ctrl_r.burst ? ST_PGAP : ST_GAP;
				end
			end
			ST_PGAP: begin
				if (env) begin
					cnt_nxt = 18'h00000;
					state_nxt = ST_SB;
				end else if (cnt_r > C_SG_MAX) begin
					state_nxt = ST_STANDBY;
				end
			end
			ST_SB: begin
				if (envFall) begin
					cnt_nxt = 18'h00000;
					if (cnt_r >= C_SB_MIN && cnt_r <= C_SG_MAX)
						state_nxt = ST_GAP;
					else
						state_nxt = ST_STANDBY;
				end else if (cnt_r > C_SG_MAX) begin
					state_nxt = ST_STANDBY;
				end
			end
			ST_GAP: begin
				if (envRise) begin
					cnt_nxt = 18'h00000;
					if (cnt_r < C_SG_MIN || cnt_r > gapMax) begin
						state_nxt = ST_STANDBY;
					end else if (ctrl_r.pattern == `LFW_PAT_MODE1) begin
						flagSet.wake = 1'b1;
						decStart = 1'b1;
						bits_nxt = 5'h00;
						state_nxt = ST_DATA;
					end else begin
						state_nxt = ST_SYNC;
					end
				end else if (cnt_r > gapMax) begin
					state_nxt = ST_STANDBY;
				end
			end
			ST_SYNC: begin
				if (envFall) begin
					if (cnt_r >= C_SGB_MIN && cnt_r <= C_SG_MAX) begin
						decStart = 1'b1;
						bits_nxt = 5'h00;
						state_nxt = ST_HDR;
					end else begin
						state_nxt = ST_STANDBY;
					end
				end else if (cnt_r > C_SG_MAX) begin
					state_nxt = ST_STANDBY;
				end
			end
			ST_HDR: begin
				if (stall || gapTo) begin
					state_nxt = ST_STANDBY;
				end else if (bitStb) begin
					sh_nxt = {sh_r[14:0], bitVal};
					bits_nxt = bits_r + 5'h01;
					if (bits_r == 5'(`LFW_HDR_BITS - 1)) begin
						bits_nxt = 5'h00;
						if ({sh_r[5:0], bitVal} != hdrCmp_r) begin
							state_nxt = ST_STANDBY;
						end else if (ctrl_r.pattern == `LFW_PAT_HDRID) begin
							state_nxt = ST_IDENT;
						end else begin
							flagSet.wake = 1'b1;
							state_nxt = ST_DATA;
						end
					end
				end
			end
			ST_IDENT: begin
				if (stall || gapTo) begin
					state_nxt = ST_STANDBY;
				end else if (bitStb) begin
					sh_nxt = {sh_r[14:0], bitVal};
					bits_nxt = bits_r + 5'h01;
					if (bits_r == 5'(`LFW_ID_BITS - 1)) begin
						bits_nxt = 5'h00;
						if ({sh_r[14:0], bitVal} == idCmp_r) begin
							flagSet.wake = 1'b1;
							state_nxt = ST_DATA;
						end else begin
							state_nxt = ST_STANDBY;
						end
					end
				end
			end
			ST_DATA: begin
				if (stall || gapTo) begin
					flagSet.eod = 1'b1;
					state_nxt = ST_STANDBY;
				end else if (bitStb) begin
					sh_nxt = {sh_r[14:0], bitVal};
					bits_nxt = bits_r + 5'h01;
					if (bits_r == 5'(`LFW_FRAME_BITS - 1)) begin
						bits_nxt = 5'h00;
						rxLoadStb = 1'b1;
						flagSet.frame = 1'b1;
					end
				end
			end
			ST_TRANSP: begin
				// The receiver never leaves on its own here.
				capPulse = (env != envPrev_r);
				if (sbReset)
					state_nxt = ST_STANDBY;
			end
		endcase
		if (!ctrl_r.en)
			state_nxt = ST_STANDBY;
	end

	// Sequencer state and registered outputs.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= ST_STANDBY;
			cnt_r <= 18'h00000;
			gap_r <= 18'h00000;
			sh_r <= 16'h0000;
			bits_r <= 5'h00;
			longGap_r <= 1'b0;
			wakeIrq <= 1'b0;
			frameIrq <= 1'b0;
			eodIrq <= 1'b0;
			demodDataOut <= 1'b0;
			captureEvent <= 1'b0;
			oscRun <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			gap_r <= gap_nxt;
			sh_r <= sh_nxt;
			bits_r <= bits_nxt;
			longGap_r <= longGap_nxt;
			wakeIrq <= flags_nxt.wake & mask_nxt.wake;
			frameIrq <= flags_nxt.frame & mask_nxt.frame;
			eodIrq <= flags_nxt.eod & mask_nxt.eod;
			demodDataOut <= (state_nxt == ST_TRANSP) & env;
			// A capture on the leaving edge would fall outside the mode.
			captureEvent <= capPulse & (state_nxt == ST_TRANSP);
			oscRun <= (state_nxt == ST_TRANSP);
		end
	end

	assign rdData = rdData_r;

endmodule

// *** verif/lfw_tx.sv ***
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Remote LF transmitter driving the envelope and preamble pins
// ----------------------------------------------------------------
module lfw_tx #(
	parameter int HB = 8
) (
	input wire logic clk,
	output logic envPin,
	output logic preamblePin
);
	// No carrier and no preamble until a frame is sent.
	initial begin
		envPin = 1'b0;
		preamblePin = 1'b0;
	end

	// Hold both pins for n cycles; the trailing delay lets edge updates land.
	task automatic lvl(input logic v, input logic p, input int n);
		@(posedge clk);
		envPin <= v;
		preamblePin <= p;
		repeat (n - 1) @(posedge clk);
		#1;
	endtask

	// Preamble, start sequence and sync burst, ending one half bit after the sync fall.
	task automatic pre(input logic bm, input int g);
		lvl(1'b1, 1'b1, 20);
		if (bm) begin
			lvl(1'b0, 1'b0, 30);
			lvl(1'b1, 1'b0, 60);
			lvl(1'b0, 1'b0, 50);
		end else begin
			lvl(1'b0, 1'b0, g);
		end
		lvl(1'b1, 1'b0, 30);
		lvl(1'b0, 1'b0, HB);
	endtask

	// Manchester, MSB first; the mid-bit level is the bit value.
	task automatic bits(input logic [15:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			lvl(!v[i], 1'b0, HB);
			lvl(v[i], 1'b0, HB);
		end
	endtask
endmodule

// *** verif/lfw_chk_props.sv ***
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module lfw_chk (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [2:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	input wire logic [7:0] rdData,
	input wire logic envPin,
	input wire logic preamblePin,
	input wire logic wakeIrq,
	input wire logic frameIrq,
	input wire logic eodIrq,
	input wire logic demodDataOut,
	input wire logic captureEvent,
	input wire logic oscRun
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	// Mask writes act at once, so a masked event cannot keep its line up.
	logic mw;
	logic cw;
	assign mw = wrStb && addr == 3'h1;
	assign cw = wrStb && addr == 3'h0;

	rd_idle_a: assert property (!$past(rdStb) |-> rdData == 8'h00)
		else $error("read data outside its slot");
	wake_mask_a: assert property (mw && !wrData[0] |-> ##[1:2] !wakeIrq)
		else $error("wake line up while masked");
	frame_mask_a: assert property (mw && !wrData[1] |-> ##[1:2] !frameIrq)
		else $error("frame line up while masked");
	eod_mask_a: assert property (mw && !wrData[2] |-> ##[1:2] !eodIrq)
		else $error("end line up while masked");
	stop_osc_a: assert property (cw && !wrData[0] |-> ##[1:2] !oscRun)
		else $error("transparent kept after disable");
	osc_hold_a: assert property (oscRun && !cw |=> oscRun)
		else $error("transparent left on its own");
	cap_first_a: assert property ($rose(oscRun) |-> ##[0:1] captureEvent)
		else $error("no first capture");
	cap_osc_a: assert property (captureEvent |-> oscRun)
		else $error("capture outside transparent");
	demod_gate_a: assert property (!oscRun |-> !demodDataOut)
		else $error("data out outside transparent");
endmodule

bind lfw_wakeup_decoder lfw_chk chk (.clk(clk), .nrst(nrst),
	.addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
	.rdData(rdData), .envPin(envPin), .preamblePin(preamblePin),
	.wakeIrq(wakeIrq), .frameIrq(frameIrq), .eodIrq(eodIrq),
	.demodDataOut(demodDataOut), .captureEvent(captureEvent),
	.oscRun(oscRun));

// *** verif/lfw_wakeup_decoder_tb_top.sv ***
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------
module lfw_wakeup_decoder_tb_top;
	import lfw_pkg::*;
	localparam int HB = 8;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wrData = 8'h00;
	logic wrStb = 1'b0;
	logic rdStb = 1'b0;
	logic [7:0] rdData;
	logic envPin, preamblePin, wakeIrq, frameIrq, eodIrq;
	logic demodDataOut, captureEvent, oscRun;
	logic [7:0] d;
	int n_mismatch = 0;
	int n_checks = 0;
	int seed = 36;
	int nCap = 0;

	// 40 MHz clock.
	always #12.5 clk = ~clk;

	// Software sees each capture event; count them as a timer would.
	always @(posedge clk) begin
		if (captureEvent)
			nCap++;
	end

	// Short counts keep each frame to a few hundred cycles.
	lfw_wakeup_decoder #(.SG_MIN(10), .SG_MAX(200), .SGB_MIN(20),
		.SB_MIN(40), .SBG_MAX(100), .HALF_BIT(HB)) dut (
		.clk(clk), .nrst(nrst), .addr(addr), .wrData(wrData),
		.wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
		.envPin(envPin), .preamblePin(preamblePin),
		.wakeIrq(wakeIrq), .frameIrq(frameIrq), .eodIrq(eodIrq),
		.demodDataOut(demodDataOut), .captureEvent(captureEvent),
		.oscRun(oscRun));
	lfw_tx #(.HB(HB)) tx (.clk(clk), .envPin(envPin),
		.preamblePin(preamblePin));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wrData <= v;
		wrStb <= 1'b1;
		@(posedge clk);
		wrStb <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe.
	task automatic rd(input logic [2:0] a);
		@(posedge clk);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge clk);
		rdStb <= 1'b0;
		#1 d = rdData;
	endtask

	function automatic logic [7:0] flagsExp(input logic bad);
		return bad ? 8'h00 : 8'h07;
	endfunction

	// One decoded frame: header, optional identifier, one data byte, stall.
	task automatic wake(input logic [1:0] pat, input logic bm,
		input logic bad);
		logic [6:0] h;
		logic [15:0] id;
		logic [7:0] dat;
		h = 7'($random(seed));
		id = 16'($random(seed));
		dat = 8'($random(seed));
		wr(3'h3, {1'b0, h});
		wr(3'h4, id[15:8]);
		wr(3'h5, id[7:0]);
		wr(3'h2, 8'h07);
		wr(3'h0, {4'h0, bm, pat, 1'b1});
		tx.pre(bm, 50);
		tx.bits({9'h0, h ^ {6'h0, bad}}, 7);
		rd(3'h2);
		chk(d, {7'h0, pat == 2'h1 && !bad});
		if (pat == 2'h2) tx.bits(id, 16);
		tx.bits({8'h0, dat}, 8);
		rd(3'h6);
		if (!bad) chk(d, dat);
		chk({7'h0, frameIrq}, {7'h0, !bad});
		tx.lvl(1'b0, 1'b0, 6 * HB);
		rd(3'h2);
		chk(d, flagsExp(bad));
		chk({7'h0, wakeIrq}, {7'h0, !bad});
		rd(3'h7);
		chk(d, 8'h00);
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// A hang is cut short well beyond the expected run length.
	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		final_report;
	end

	// Main sequence: header and identifier modes, faults, then transparent mode.
	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		wr(3'h1, 8'h07);
		wake(2'h1, 1'b0, 1'b0);
		wake(2'h2, 1'b0, 1'b0);
		wake(2'h1, 1'b1, 1'b0);
		wake(2'h2, 1'b1, 1'b0);
		wr(3'h1, 8'h00);
		#1;
		chk({5'h0, eodIrq, frameIrq, wakeIrq}, 8'h00);
		wr(3'h1, 8'h07);
		wake(2'h2, 1'b0, 1'b1);
		wake(2'h1, 1'b1, 1'b1);
		for (int i = 0; i < 4; i++) begin
			wake(2'h1 + 2'($random(seed) & 1), 1'($random(seed)),
				($random(seed) & 3) == 0);
		end
		// A start gap past its limit must not wake.
		wr(3'h2, 8'h07);
		wr(3'h0, 8'h03);
		tx.pre(1'b0, 250);
		rd(3'h2);
		chk(d, 8'h00);
		// Disable in mid header drops to standby.
		tx.pre(1'b0, 50);
		tx.bits(16'h0005, 3);
		wr(3'h0, 8'h00);
		rd(3'h7);
		chk(d, 8'h00);
		// Transparent mode, left here by the standby reset bit.
		wr(3'h1, 8'h06);
		wr(3'h0, 8'h07);
		tx.lvl(1'b1, 1'b1, 20);
		chk({7'h0, oscRun}, 8'h01);
		rd(3'h7);
		chk(d, 8'h09);
		tx.lvl(1'b0, 1'b0, 10);
		chk({7'h0, demodDataOut}, 8'h00);
		tx.lvl(1'b1, 1'b0, 10);
		chk({7'h0, demodDataOut}, 8'h01);
		chk({7'h0, oscRun}, 8'h01);
		chk({7'h0, wakeIrq}, 8'h00);
		wr(3'h0, 8'h17);
		tx.lvl(1'b0, 1'b0, 4);
		chk({7'h0, oscRun}, 8'h00);
		chk(8'(nCap), 8'h03);
		wr(3'h0, 8'h01);
		wr(3'h1, 8'h07);
		final_report;
	end
endmodule
